//--- drtp_pkg.sv
// Shared constants and carrier types for the dual reload timer pair.
package drtp_pkg;
	// Register byte addresses on the special function register port.
	localparam logic [15:0] ADDR_CTRL = 16'hff50;
	localparam logic [15:0] ADDR_IC_A = 16'hff9c;
	localparam logic [15:0] ADDR_IC_B = 16'hff9e;
	localparam logic [15:0] ADDR_CNT_A = 16'hfe50;
	localparam logic [15:0] ADDR_CNT_B = 16'hfe52;
	localparam logic [15:0] ADDR_REL_A = 16'hfe54;
	localparam logic [15:0] ADDR_REL_B = 16'hfe56;
	// Reset values and the writable bits of the shared control register.
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h4f4f;
	localparam logic [7:0] IC_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// Field positions inside the shared control register.
	localparam int RUN_A_BIT = 6;
	localparam int MODE_A_BIT = 3;
	localparam int SEL_A_LSB = 0;
	localparam int RUN_B_BIT = 14;
	localparam int MODE_B_BIT = 11;
	localparam int SEL_B_LSB = 8;
	// Field positions inside each interrupt control register.
	localparam int IC_FLAG_BIT = 7;
	localparam int IC_EN_BIT = 6;
	localparam int IC_LEVEL_LSB = 2;
	localparam int IC_GROUP_LSB = 0;
	// Counter mode source codes in the low two bits of the select field.
	localparam logic [1:0] SRC_GPT = 2'h0;
	localparam logic [1:0] SRC_RISE = 2'h1;
	localparam logic [1:0] SRC_FALL = 2'h2;
	localparam logic [1:0] SRC_BOTH = 2'h3;
	// Timing: one state is two oscillator periods, and one state is one clk.
	localparam int OSC_PER_STATE = 2;
	localparam int BASE_DIV_OSC = 16;
	localparam int BASE_DIV_STATES = BASE_DIV_OSC / OSC_PER_STATE;
	localparam int PRE_W = 11;
	localparam logic [PRE_W-1:0] PRE_BASE_MASK = PRE_W'(BASE_DIV_STATES - 1);
	// Layout of the shared control register.
	typedef struct packed {
		logic rsv15;
		logic run_b;
		logic [1:0] rsv13;
		logic mode_b;
		logic [2:0] sel_b;
		logic rsv7;
		logic run_a;
		logic [1:0] rsv5;
		logic mode_a;
		logic [2:0] sel_a;
	} drtp_ctrl_s;
	// Layout of an interrupt control register.
	typedef struct packed {
		logic flag;
		logic enable;
		logic [3:0] priority_level;
		logic [1:0] group_priority;
	} drtp_ic_s;
endpackage

//--- drtp_timer_pair.sv
// Two 16-bit up-counting reload timers with their interrupt control registers.
`timescale 1ns/1ns

// Notes on behaviour
// - Timers count only while run bit set, except one due step of the second.
// - Mode bit one selects counter, zero timer mode.
// - Three-bit select field picks prescaler or source.
// - Reserved control bits do nothing, read zero.
// - Counters count upward; counts readable and writable.
// - CPU write beats a same-cycle increment or reload.
// - Timer mode divides oscillator by sixteen times power.
// - Wrap from all ones loads reload value.
// - Overflow period follows prescale times reload distance.
// - First tick within one interval, then exact.
// - Second timer serviced one state after first.
// - Select low bits 00 count general timer overflows.
// - Second timer counter mode other codes stops it.
// - First timer counts rising, falling or both pin edges.
// - Pin count rate at most oscillator over sixteen.
// - Pin edge reaches count within eight states.
// - Pin as output: port data bit clocks first timer.
// - Overflow sets the timer's request flag, bit 7.
// - Request forwarded only while enable bit 6 set.
// - Priority level bits 5:2, group bits 1:0.
// - Reset clears control register: stopped, timer mode.
module drtp_timer_pair (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic external_count_pin,
	input wire logic count_pin_is_output,
	input wire logic count_pin_port_data,
	input wire logic general_timer_overflow_src,
	output logic timer_a_vector,
	output logic timer_b_vector
);

	drtp_pkg::drtp_ctrl_s timer_pair_control, next_timer_pair_control;
	drtp_pkg::drtp_ic_s timer_a_irq_control, next_timer_a_irq_control;
	drtp_pkg::drtp_ic_s timer_b_irq_control, next_timer_b_irq_control;
	logic [15:0] timer_a, next_timer_a, timer_b, next_timer_b;
	logic [15:0] timer_a_reload, next_timer_a_reload, timer_b_reload, next_timer_b_reload;
	logic [drtp_pkg::PRE_W-1:0] prescale, next_prescale;
	logic [2:0] pin_sync, next_pin_sync, gpt_sync, next_gpt_sync;
	logic pin_level, next_pin_level, gpt_level, next_gpt_level;
	logic inc_b_due, next_inc_b_due;
	logic [15:0] next_reg_rdata;
	logic next_timer_a_vector, next_timer_b_vector;
	logic pin_change, pin_rise, pin_fall, gpt_event;
	logic tick_a, tick_b, inc_a, inc_b_raw, ovf_a, ovf_b;
	logic wr_ctrl, wr_ic_a, wr_ic_b, wr_cnt_a, wr_cnt_b, wr_rel_a, wr_rel_b;
	logic [16:0] step_a, step_b;

	// True on the last clk of a prescale period of 8 << sel clocks.
	function automatic logic prescale_tick(input logic [drtp_pkg::PRE_W-1:0] cnt,
		input logic [2:0] sel);
		logic [drtp_pkg::PRE_W-1:0] mask;
		mask = drtp_pkg::PRE_W'({drtp_pkg::PRE_BASE_MASK, 7'h7f} >> (3'h7 - sel));
		return (cnt & mask) == mask;
	endfunction

	// One counting step; bit 16 of the result flags an overflow with reload.
	function automatic logic [16:0] count_step(input logic [15:0] cnt,
		input logic [15:0] rel, input logic [15:0] wdata, input logic inc, input logic wr);
		if (wr) begin
			return {1'b0, wdata};
		end else if (inc && cnt == drtp_pkg::CNT_MAX) begin
			return {1'b1, rel};
		end else if (inc) begin
			return {1'b0, cnt + drtp_pkg::CNT_ONE};
		end
		return {1'b0, cnt};
	endfunction

	// Address decode of the register port writes.
	assign wr_ctrl = reg_wr && reg_addr == drtp_pkg::ADDR_CTRL;
	assign wr_ic_a = reg_wr && reg_addr == drtp_pkg::ADDR_IC_A;
	assign wr_ic_b = reg_wr && reg_addr == drtp_pkg::ADDR_IC_B;
	assign wr_cnt_a = reg_wr && reg_addr == drtp_pkg::ADDR_CNT_A;
	assign wr_cnt_b = reg_wr && reg_addr == drtp_pkg::ADDR_CNT_B;
	assign wr_rel_a = reg_wr && reg_addr == drtp_pkg::ADDR_REL_A;
	assign wr_rel_b = reg_wr && reg_addr == drtp_pkg::ADDR_REL_B;

	// Input synchronisers; a level counts once the second and third stages agree.
	// Only the second stage reads the first, so metastability cannot reach the edge logic.
	always_comb begin
		next_pin_sync = {pin_sync[1:0],
			count_pin_is_output ? count_pin_port_data : external_count_pin};
		next_gpt_sync = {gpt_sync[1:0], general_timer_overflow_src};
		// Three stages and one count edge keep the pin latency near four states.
		pin_change = pin_sync[1] == pin_sync[2] && pin_sync[2] != pin_level;
		pin_rise = pin_change && pin_sync[2];
		pin_fall = pin_change && !pin_sync[2];
		gpt_event = gpt_sync[1] == gpt_sync[2] && gpt_sync[2] != gpt_level;
		next_pin_level = pin_change ? pin_sync[2] : pin_level;
		next_gpt_level = gpt_event ? gpt_sync[2] : gpt_level;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_sync <= 3'h0;
			gpt_sync <= 3'h0;
			pin_level <= 1'b0;
			gpt_level <= 1'b0;
		end else begin
			pin_sync <= next_pin_sync;
			gpt_sync <= next_gpt_sync;
			pin_level <= next_pin_level;
			gpt_level <= next_gpt_level;
		end
	end

	// Free-running prescaler shared by both timers, so a newly started timer
	// sees its first tick within one period rather than exactly one period.
	always_comb begin
		next_prescale = prescale + drtp_pkg::PRE_W'(1);
		tick_a = prescale_tick(prescale, timer_pair_control.sel_a);
		tick_b = prescale_tick(prescale, timer_pair_control.sel_b);
	end

	// Increment sources for each timer, selected by mode and select field.
	always_comb begin
		inc_a = 1'b0;
		if (timer_pair_control.run_a) begin
			if (!timer_pair_control.mode_a) begin
				inc_a = tick_a;
			end else begin
				case (timer_pair_control.sel_a[1:0])
					drtp_pkg::SRC_GPT: inc_a = gpt_event;
					drtp_pkg::SRC_RISE: inc_a = pin_rise;
					drtp_pkg::SRC_FALL: inc_a = pin_fall;
					drtp_pkg::SRC_BOTH: inc_a = pin_change;
					default: inc_a = 1'b0;
				endcase
			end
		end
		inc_b_raw = 1'b0;
		if (timer_pair_control.run_b) begin
			if (!timer_pair_control.mode_b) begin
				inc_b_raw = tick_b;
			end else begin
				inc_b_raw = gpt_event && timer_pair_control.sel_b[1:0] == drtp_pkg::SRC_GPT;
			end
		end
		// The second timer acts one state late so both never update in one state while both use the prescaler or both use the general timer source.
		next_inc_b_due = inc_b_raw;
	end

	// Counts, reloads and control; a CPU write takes the place of a due step.
	always_comb begin
		step_a = count_step(timer_a, timer_a_reload, reg_wdata, inc_a, wr_cnt_a);
		step_b = count_step(timer_b, timer_b_reload, reg_wdata, inc_b_due, wr_cnt_b);
		ovf_a = step_a[16];
		ovf_b = step_b[16];
		next_timer_a = step_a[15:0];
		next_timer_b = step_b[15:0];
		next_timer_a_reload = wr_rel_a ? reg_wdata : timer_a_reload;
		next_timer_b_reload = wr_rel_b ? reg_wdata : timer_b_reload;
		next_timer_pair_control = wr_ctrl ? drtp_pkg::drtp_ctrl_s'(reg_wdata & drtp_pkg::CTRL_WMASK)
			: timer_pair_control;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_pair_control <= drtp_pkg::CTRL_RESET;
			prescale <= '0;
			inc_b_due <= 1'b0;
			timer_a <= drtp_pkg::CNT_RESET;
			timer_b <= drtp_pkg::CNT_RESET;
			timer_a_reload <= drtp_pkg::CNT_RESET;
			timer_b_reload <= drtp_pkg::CNT_RESET;
		end else begin
			timer_pair_control <= next_timer_pair_control;
			prescale <= next_prescale;
			inc_b_due <= next_inc_b_due;
			timer_a <= next_timer_a;
			timer_b <= next_timer_b;
			timer_a_reload <= next_timer_a_reload;
			timer_b_reload <= next_timer_b_reload;
		end
	end

	// Interrupt control: an overflow sets the flag even when software clears it
	// in the same cycle, so no request is lost.
	always_comb begin
		next_timer_a_irq_control = wr_ic_a ? drtp_pkg::drtp_ic_s'(reg_wdata[7:0])
			: timer_a_irq_control;
		next_timer_b_irq_control = wr_ic_b ? drtp_pkg::drtp_ic_s'(reg_wdata[7:0])
			: timer_b_irq_control;
		if (ovf_a) begin
			next_timer_a_irq_control.flag = 1'b1;
		end
		if (ovf_b) begin
			next_timer_b_irq_control.flag = 1'b1;
		end
		next_timer_a_vector = timer_a_irq_control.flag && timer_a_irq_control.enable;
		next_timer_b_vector = timer_b_irq_control.flag && timer_b_irq_control.enable;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_a_irq_control <= drtp_pkg::IC_RESET;
			timer_b_irq_control <= drtp_pkg::IC_RESET;
			timer_a_vector <= 1'b0;
			timer_b_vector <= 1'b0;
		end else begin
			timer_a_irq_control <= next_timer_a_irq_control;
			timer_b_irq_control <= next_timer_b_irq_control;
			timer_a_vector <= next_timer_a_vector;
			timer_b_vector <= next_timer_b_vector;
		end
	end

	// Read data is registered and holds until the next read; unmapped reads give zero.
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				drtp_pkg::ADDR_CTRL: next_reg_rdata = timer_pair_control;
				drtp_pkg::ADDR_IC_A: next_reg_rdata = {8'h00, timer_a_irq_control};
				drtp_pkg::ADDR_IC_B: next_reg_rdata = {8'h00, timer_b_irq_control};
				drtp_pkg::ADDR_CNT_A: next_reg_rdata = timer_a;
				drtp_pkg::ADDR_CNT_B: next_reg_rdata = timer_b;
				drtp_pkg::ADDR_REL_A: next_reg_rdata = timer_a_reload;
				drtp_pkg::ADDR_REL_B: next_reg_rdata = timer_b_reload;
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_reserved_read_zero: assert property (
		reg_rd && reg_addr == drtp_pkg::ADDR_CTRL |=> (reg_rdata & ~drtp_pkg::CTRL_WMASK) == 16'h0000)
		else $error("Reserved control bits read back nonzero.");
	chk_stopped_holds: assert property (
		!timer_pair_control.run_a && !wr_cnt_a |=> timer_a == $past(timer_a))
		else $error("Stopped first timer changed.");
	chk_wrap_reloads: assert property (
		inc_a && timer_a == drtp_pkg::CNT_MAX && !wr_cnt_a
		|=> timer_a == $past(timer_a_reload) && timer_a_irq_control.flag)
		else $error("Wrap did not reload and flag.");
	chk_write_wins: assert property (
		wr_cnt_b |=> timer_b == $past(reg_wdata))
		else $error("Count write lost to a timer step.");
	chk_flag_set_wins: assert property (
		ovf_b && wr_ic_b |=> timer_b_irq_control.flag)
		else $error("Overflow flag lost to a clear.");
	chk_vector_gated: assert property (
		timer_a_vector |-> $past(timer_a_irq_control.flag) && $past(timer_a_irq_control.enable))
		else $error("Request forwarded while disabled.");
	chk_b_one_state_late: assert property (
		inc_b_raw |=> inc_b_due ##1 ($past(wr_cnt_b) || timer_b != $past(timer_b)))
		else $error("Second timer not serviced one state later.");
	chk_b_counter_stop: assert property (
		timer_pair_control.mode_b && timer_pair_control.sel_b[1:0] != drtp_pkg::SRC_GPT
		&& !inc_b_due && !wr_cnt_b |=> timer_b == $past(timer_b))
		else $error("Second timer ran on an invalid counter source.");
	chk_first_tick_bound: assert property (
		$rose(timer_pair_control.run_a) && !timer_pair_control.mode_a
		&& timer_pair_control.sel_a == 3'h0 |-> ##[0:7] tick_a)
		else $error("First tick later than one interval.");
	chk_pin_latency: assert property (
		timer_pair_control.run_a && timer_pair_control.mode_a
		&& timer_pair_control.sel_a[1:0] == drtp_pkg::SRC_BOTH && !wr_cnt_a && pin_change
		|=> timer_a != $past(timer_a))
		else $error("Pin edge not counted in time.");
	// Second timer wrap, its request path, the first timer's count sources and its interrupt control write.
	chk_b_wrap_reloads: assert property (
		inc_b_due && timer_b == drtp_pkg::CNT_MAX && !wr_cnt_b
		|=> timer_b == $past(timer_b_reload) && timer_b_irq_control.flag)
		else $error("Second timer wrap did not reload and flag.");
	chk_vector_b_gated: assert property (
		timer_b_vector |-> $past(timer_b_irq_control.flag) && $past(timer_b_irq_control.enable))
		else $error("Second request forwarded while disabled.");
	chk_gpt_counts_a: assert property (
		timer_pair_control.run_a && timer_pair_control.mode_a && gpt_event && !wr_cnt_a
		&& timer_pair_control.sel_a[1:0] == drtp_pkg::SRC_GPT
		|=> timer_a == $past(timer_a) + drtp_pkg::CNT_ONE || $past(timer_a) == drtp_pkg::CNT_MAX)
		else $error("General timer overflow not counted.");
	chk_rise_skips_fall: assert property (
		timer_pair_control.run_a && timer_pair_control.mode_a && pin_fall && !wr_cnt_a
		&& timer_pair_control.sel_a[1:0] == drtp_pkg::SRC_RISE |=> timer_a == $past(timer_a))
		else $error("Falling pin edge counted in rising mode.");
	chk_ic_write_lands: assert property (
		wr_ic_a && !ovf_a |=> timer_a_irq_control == $past(reg_wdata[7:0]))
		else $error("Interrupt control write lost.");

endmodule

//--- drtp_source_model.sv
// Far side model: the external count pin and the general timer overflow toggle.
`timescale 1ns/1ns
module drtp_source_model (
	input wire logic clk,
	input wire logic pin_go,
	input wire logic gpt_go,
	output logic pin,
	output logic gpt
);
	int phase = 0;
	logic pin_q = 1'b0;
	logic gpt_q = 1'b0;
	// One process owns each level, so the outputs have a single driver.
	assign pin = pin_q;
	assign gpt = gpt_q;
	// Each level is held eight states, so no edge is lost and the rate stays legal.
	always @(posedge clk) begin
		if (pin_go || gpt_go) begin
			phase <= (phase + 1) % 8;
			if (phase == 7) begin
				pin_q <= pin_q ^ pin_go;
				gpt_q <= gpt_q ^ gpt_go;
			end
		end else begin
			phase <= 0;
		end
	end
endmodule

//--- test_drtp_timer_pair.sv
// Self-checking testbench for the dual reload timer pair.
`timescale 1ns/1ns
module test_drtp_timer_pair;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic cpo = 1'b0;
	logic cpd = 1'b0;
	logic pin_go = 1'b0;
	logic gpt_go = 1'b0;
	logic ext_pin;
	logic gpt;
	logic va;
	logic vb;
	int num_errors = 0;
	int n_tests = 0;
	// Clock of 20 ns period.
	always #10 clk = ~clk;
	drtp_timer_pair uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.external_count_pin(ext_pin), .count_pin_is_output(cpo), .count_pin_port_data(cpd),
		.general_timer_overflow_src(gpt), .timer_a_vector(va), .timer_b_vector(vb));
	drtp_source_model src (.clk(clk), .pin_go(pin_go), .gpt_go(gpt_go), .pin(ext_pin),
		.gpt(gpt));
	task print_verdict;
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus cycles: strobes rise at a falling edge and fall one cycle later.
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	task rchk(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		check(d, exp);
	endtask
	task cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Polls every two cycles until the count moves, so the gap is measured exactly.
	task next_step(input logic [15:0] a, inout logic [15:0] v, output int k);
		logic [15:0] n;
		k = 0;
		n = v;
		while (n === v && k < 300) begin
			rd(a, n);
			k++;
		end
		check(n, v + 16'h0001);
		v = n;
	endtask
	task scn_reset_regs;
		rchk(drtp_pkg::ADDR_CTRL, 16'h0000);
		rchk(drtp_pkg::ADDR_IC_A, 16'h0000);
		rchk(drtp_pkg::ADDR_IC_B, 16'h0000);
		rchk(drtp_pkg::ADDR_CNT_B, 16'h0000);
		wr(drtp_pkg::ADDR_CTRL, 16'hffff);
		rchk(drtp_pkg::ADDR_CTRL, 16'h4f4f);
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
		rchk(16'hff00, 16'h0000);
		wr(drtp_pkg::ADDR_REL_B, 16'h5a5a);
		rchk(drtp_pkg::ADDR_REL_B, 16'h5a5a);
		wr(drtp_pkg::ADDR_CNT_A, 16'h1234);
		cycles(100);
		rchk(drtp_pkg::ADDR_CNT_A, 16'h1234);
	endtask
	task scn_prescale;
		logic [15:0] a;
		logic [15:0] v;
		int k;
		for (int t = 0; t < 2; t++) begin
			for (int s = 0; s < 4; s++) begin
				a = t ? drtp_pkg::ADDR_CNT_B : drtp_pkg::ADDR_CNT_A;
				wr(a, 16'h0000);
				v = 16'h0000;
				wr(drtp_pkg::ADDR_CTRL, t ? 16'h4000 | 16'(s << 8) : 16'h0040 | 16'(s));
				next_step(a, v, k);
				// A read sees a step one edge late and reads come two cycles apart.
				check(16'(2 * k <= (8 << s) + 2), 16'h0001);
				next_step(a, v, k);
				check(16'(2 * k), 16'(8 << s));
				wr(drtp_pkg::ADDR_CTRL, 16'h0000);
			end
		end
	endtask
	// Overflow reloads the count, raises the flag and, when enabled, the vector.
	task scn_reload;
		int k;
		wr(drtp_pkg::ADDR_CNT_A, 16'hfffe);
		wr(drtp_pkg::ADDR_REL_A, 16'hfff0);
		wr(drtp_pkg::ADDR_IC_A, 16'h0040);
		wr(drtp_pkg::ADDR_CTRL, 16'h0040);
		k = 0;
		while (va !== 1'b1 && k < 40) begin
			cycles(1);
			k++;
		end
		check({15'h0000, va}, 16'h0001);
		rchk(drtp_pkg::ADDR_CNT_A, 16'hfff0);
		rchk(drtp_pkg::ADDR_IC_A, 16'h00c0);
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
		wr(drtp_pkg::ADDR_IC_A, 16'h003f);
		rchk(drtp_pkg::ADDR_IC_A, 16'h003f);
		wr(drtp_pkg::ADDR_CNT_A, 16'hfffe);
		wr(drtp_pkg::ADDR_CTRL, 16'h0040);
		cycles(30);
		rchk(drtp_pkg::ADDR_IC_A, 16'h00bf);
		check({15'h0000, va}, 16'h0000);
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
	endtask
	// Second timer overflows under a stream of clearing writes; the flag must still show.
	task scn_flag_race;
		logic seen;
		seen = 1'b0;
		wr(drtp_pkg::ADDR_IC_B, 16'h0040);
		wr(drtp_pkg::ADDR_CNT_B, 16'hfffe);
		wr(drtp_pkg::ADDR_CTRL, 16'h4000);
		@(negedge clk);
		reg_addr = drtp_pkg::ADDR_IC_B;
		reg_wdata = 16'h0040;
		reg_wr = 1'b1;
		repeat (24) begin
			@(negedge clk);
			seen = seen | vb;
		end
		reg_wr = 1'b0;
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
		check({15'h0000, seen}, 16'h0001);
		rchk(drtp_pkg::ADDR_IC_B, 16'h0040);
	endtask
	// Rising, falling and both-edge counting on the pin, then software clocking.
	task scn_pin;
		for (int s = 1; s < 4; s++) begin
			wr(drtp_pkg::ADDR_CNT_A, 16'h0000);
			wr(drtp_pkg::ADDR_CTRL, 16'h0048 | 16'(s));
			pin_go = 1'b1;
			cycles(64);
			pin_go = 1'b0;
			cycles(10);
			rchk(drtp_pkg::ADDR_CNT_A, s == 3 ? 16'h0008 : 16'h0004);
		end
		cpo = 1'b1;
		wr(drtp_pkg::ADDR_CNT_A, 16'h0000);
		wr(drtp_pkg::ADDR_CTRL, 16'h0049);
		for (int i = 1; i < 4; i++) begin
			cpd = 1'b1;
			cycles(6);
			rchk(drtp_pkg::ADDR_CNT_A, 16'(i));
			cpd = 1'b0;
			cycles(8);
		end
		cpo = 1'b0;
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
	endtask
	task scn_gpt;
		wr(drtp_pkg::ADDR_CNT_A, 16'h0000);
		wr(drtp_pkg::ADDR_CNT_B, 16'h0000);
		wr(drtp_pkg::ADDR_CTRL, 16'h4c4c);
		gpt_go = 1'b1;
		cycles(48);
		gpt_go = 1'b0;
		cycles(10);
		rchk(drtp_pkg::ADDR_CNT_A, 16'h0006);
		rchk(drtp_pkg::ADDR_CNT_B, 16'h0006);
		wr(drtp_pkg::ADDR_CTRL, 16'h4d4c);
		gpt_go = 1'b1;
		cycles(16);
		gpt_go = 1'b0;
		cycles(10);
		rchk(drtp_pkg::ADDR_CNT_B, 16'h0006);
		rchk(drtp_pkg::ADDR_CNT_A, 16'h0008);
		wr(drtp_pkg::ADDR_CTRL, 16'h0000);
	endtask
	// Main sequence: reset for sixteen cycles, then every scenario in turn.
	initial begin
		cycles(16);
		rst = 1'b0;
		scn_reset_regs();
		scn_prescale();
		scn_reload();
		scn_flag_race();
		scn_pin();
		scn_gpt();
		print_verdict();
	end
	// The tests need a small part of these ten thousand cycles; a hang ends the run here.
	initial begin
		#200000;
		num_errors++;
		print_verdict();
	end
endmodule
